// File: hdl/sss_sequencer.sv
// Step/scan sequencer: channel closures, reading storage and output triggers
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_sequencer
    import sss_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  step_start_i,
    input  wire logic                  scan_start_i,
    input  wire logic                  halt_i,
    input  wire logic                  external_mode_i,
    input  wire logic [`SSS_CH_W-1:0]  first_ch_i,
    input  wire logic [`SSS_CH_W-1:0]  last_ch_i,
    input  wire logic [`SSS_CNT_W-1:0] reading_count_setting_i,
    input  wire logic                  timer_en_i,
    input  wire logic [`SSS_MS_W-1:0]  timer_ms_i,
    input  wire logic [`SSS_MS_W-1:0]  delay_ms_i,
    input  wire logic                  outside_trigger_source_i,
    input  wire logic                  reading_done_i,
    output logic                       busy_o,
    output logic                       scan_mode_o,
    output logic [`SSS_CH_W-1:0]       closed_ch_o,
    output logic                       relay_close_o,
    output logic                       measure_req_o,
    output logic                       store_we_o,
    output logic [`SSS_CNT_W-1:0]      store_addr_o,
    output logic                       out_trig_o,
    output logic                       ref_junction_o,
    output logic [`SSS_CNT_W-1:0]      sample_count_o,
    output logic [`SSS_CNT_W-1:0]      trigger_count_o
);
    sss_state_t               state_reg, state_next;
    logic                     scan_reg, scan_next;
    logic                     ext_reg, ext_next;
    logic                     tmr_en_reg, tmr_en_next;
    logic [`SSS_CH_W-1:0]     first_reg, first_next;
    logic [`SSS_CH_W-1:0]     last_reg, last_next;
    logic [`SSS_CH_W-1:0]     ch_reg, ch_next;
    logic [`SSS_CNT_W-1:0]    reading_count_setting_reg, reading_count_setting_next;
    logic [`SSS_CNT_W-1:0]    stored_reg, stored_next;
    logic [`SSS_CNT_W-1:0]    done_reg, done_next;
    logic [`SSS_MS_W-1:0]     tmr_ms_reg, tmr_ms_next;
    logic [`SSS_MS_W-1:0]     dly_ms_reg, dly_ms_next;
    logic [`SSS_MS_W-1:0]     tmr_cnt_reg, tmr_cnt_next;
    logic [`SSS_MS_W-1:0]     dly_cnt_reg, dly_cnt_next;
    logic [31:0]              tick_reg, tick_next;
    logic                     first_pass_reg, first_pass_next;
    logic                     relay_reg, relay_next;
    logic                     meas_reg, meas_next;
    logic                     we_reg, we_next;
    logic [`SSS_CNT_W-1:0]    addr_reg, addr_next;
    logic                     trig_reg, trig_next;
    logic                     refj_reg, refj_next;
    logic [`SSS_CNT_W-1:0]    samp_reg, samp_next;
    logic [`SSS_CNT_W-1:0]    tcnt_reg, tcnt_next;
    logic [`SSS_CNT_W-1:0]    list_len;
    logic [`SSS_CNT_W-1:0]    cfg_len;
    logic [`SSS_CNT_W-1:0]    cfg_rdg;
    logic [`SSS_CNT_W-1:0]    cfg_ceil;
    logic                     ms_tick;
    logic                     last_in_pass;
    logic                     all_done;

    assign ms_tick      = (tick_reg == 32'(`SSS_MS_CYCLES - 1));
    assign list_len     = `SSS_CNT_W'(last_reg - first_reg) + `SSS_CNT_W'(1);
    assign cfg_len      = (last_ch_i >= first_ch_i)
                        ? `SSS_CNT_W'(last_ch_i - first_ch_i) + `SSS_CNT_W'(1)
                        : `SSS_CNT_W'(1);
    // Clamp to the documented maximum; zero is taken as one reading
    assign cfg_rdg      = (reading_count_setting_i > `SSS_MAX_RDG) ? `SSS_MAX_RDG
                        : (reading_count_setting_i == '0) ? `SSS_CNT_W'(1)
                        : reading_count_setting_i;
    assign cfg_ceil     = `SSS_CNT_W'((cfg_rdg + cfg_len - `SSS_CNT_W'(1)) / cfg_len);
    assign last_in_pass = (ch_reg == last_reg);
    assign all_done     = (done_reg >= reading_count_setting_reg);

    always_comb begin
        state_next      = state_reg;
        scan_next       = scan_reg;
        ext_next        = ext_reg;
        tmr_en_next     = tmr_en_reg;
        first_next      = first_reg;
        last_next       = last_reg;
        ch_next         = ch_reg;
        reading_count_setting_next    = reading_count_setting_reg;
        stored_next     = stored_reg;
        done_next       = done_reg;
        tmr_ms_next     = tmr_ms_reg;
        dly_ms_next     = dly_ms_reg;
        first_pass_next = first_pass_reg;
        relay_next      = relay_reg;
        meas_next       = 1'b0;
        we_next         = 1'b0;
        addr_next       = addr_reg;
        trig_next       = 1'b0;
        refj_next       = refj_reg;
        samp_next       = samp_reg;
        tcnt_next       = tcnt_reg;
        tick_next       = ms_tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
        // Interval timer runs freely during an operation, restarted at each closure
        tmr_cnt_next    = (ms_tick && tmr_cnt_reg != '0) ? tmr_cnt_reg - 1'b1 : tmr_cnt_reg;
        dly_cnt_next    = (ms_tick && dly_cnt_reg != '0) ? dly_cnt_reg - 1'b1 : dly_cnt_reg;
        case (state_reg)
            SSS_IDLE: begin
                relay_next = 1'b0;
                refj_next  = 1'b0;
                if (step_start_i || scan_start_i) begin
                    // Settings are latched only here
                    scan_next       = scan_start_i && !step_start_i;
                    ext_next        = external_mode_i;
                    first_next      = first_ch_i;
                    last_next       = (last_ch_i >= first_ch_i) ? last_ch_i : first_ch_i;
                    reading_count_setting_next    = cfg_rdg;
                    tmr_en_next     = timer_en_i;
                    tmr_ms_next     = timer_ms_i;
                    dly_ms_next     = delay_ms_i;
                    ch_next         = first_ch_i;
                    stored_next     = '0;
                    done_next       = '0;
                    addr_next       = '0;
                    first_pass_next = 1'b1;
                    tmr_cnt_next    = '0;
                    samp_next       = scan_next ? cfg_len : `SSS_CNT_W'(1);
                    tcnt_next       = scan_next ? cfg_ceil : cfg_rdg;
                    state_next      = SSS_DELAY;
                    dly_cnt_next    = delay_ms_i;
                end
            end
            SSS_DELAY: begin
                if (dly_cnt_reg == '0) begin
                    state_next = SSS_WAIT_TIMER;
                end
            end
            SSS_WAIT_TIMER: begin
                // Timer was armed when the previous closure began after its delay,
                // so a long delay already covers the interval
                if (!tmr_en_reg || first_pass_reg || tmr_cnt_reg == '0) begin
                    first_pass_next = 1'b0;
                    tmr_cnt_next    = tmr_ms_reg;
                    state_next      = SSS_CLOSE;
                end
            end
            SSS_CLOSE: begin
                relay_next = !ext_reg;
                refj_next  = (ch_reg == `SSS_REF_CH);
                meas_next  = !ext_reg;
                state_next = SSS_MEASURE;
            end
            SSS_MEASURE: begin
                if ((ext_reg && outside_trigger_source_i) || (!ext_reg && reading_done_i)) begin
                    if (stored_reg < reading_count_setting_reg) begin
                        we_next     = 1'b1;
                        addr_next   = stored_reg;
                        stored_next = stored_reg + 1'b1;
                    end
                    done_next  = done_reg + 1'b1;
                    state_next = SSS_NEXT;
                end
            end
            SSS_NEXT: begin
                if (!scan_reg) begin
                    trig_next = 1'b1;
                end else if (last_in_pass) begin
                    trig_next = 1'b1;
                end
                ch_next = last_in_pass ? first_reg : ch_reg + 1'b1;
                if (!scan_reg) begin
                    // Step: each closure is its own paced event
                    state_next = all_done ? SSS_IDLE : SSS_DELAY;
                end else if (last_in_pass) begin
                    state_next = all_done ? SSS_IDLE : SSS_DELAY;
                end else begin
                    // Scan: channels inside a pass are not timer paced
                    state_next = SSS_DELAY;
                    first_pass_next = 1'b1;
                end
                if (!scan_reg || last_in_pass) begin
                    first_pass_next = 1'b0;
                end
                dly_cnt_next = dly_ms_reg;
                relay_next   = 1'b0;
                // Reference flag belongs to the closure that just finished
                refj_next    = 1'b0;
            end
            default: state_next = SSS_IDLE;
        endcase
        if (halt_i) begin
            state_next = SSS_IDLE;
            relay_next = 1'b0;
            refj_next  = 1'b0;
            trig_next  = 1'b0;
            meas_next  = 1'b0;
            we_next    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_reg      <= SSS_IDLE;
            scan_reg       <= 1'b0;
            ext_reg        <= 1'b0;
            tmr_en_reg     <= 1'b0;
            first_reg      <= '0;
            last_reg       <= '0;
            ch_reg         <= '0;
            reading_count_setting_reg    <= '0;
            stored_reg     <= '0;
            done_reg       <= '0;
            tmr_ms_reg     <= '0;
            dly_ms_reg     <= '0;
            tmr_cnt_reg    <= '0;
            dly_cnt_reg    <= '0;
            tick_reg       <= '0;
            first_pass_reg <= 1'b0;
            relay_reg      <= 1'b0;
            meas_reg       <= 1'b0;
            we_reg         <= 1'b0;
            addr_reg       <= '0;
            trig_reg       <= 1'b0;
            refj_reg       <= 1'b0;
            samp_reg       <= '0;
            tcnt_reg       <= '0;
        end else begin
            state_reg      <= state_next;
            scan_reg       <= scan_next;
            ext_reg        <= ext_next;
            tmr_en_reg     <= tmr_en_next;
            first_reg      <= first_next;
            last_reg       <= last_next;
            ch_reg         <= ch_next;
            reading_count_setting_reg    <= reading_count_setting_next;
            stored_reg     <= stored_next;
            done_reg       <= done_next;
            tmr_ms_reg     <= tmr_ms_next;
            dly_ms_reg     <= dly_ms_next;
            tmr_cnt_reg    <= tmr_cnt_next;
            dly_cnt_reg    <= dly_cnt_next;
            tick_reg       <= tick_next;
            first_pass_reg <= first_pass_next;
            relay_reg      <= relay_next;
            meas_reg       <= meas_next;
            we_reg         <= we_next;
            addr_reg       <= addr_next;
            trig_reg       <= trig_next;
            refj_reg       <= refj_next;
            samp_reg       <= samp_next;
            tcnt_reg       <= tcnt_next;
        end
    end

    // Step or scan in progress; list_len feeds only this busy term and is never zero
    logic busy_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != SSS_IDLE) && (list_len != '0);
        end
    end

    assign busy_o          = busy_reg;
    assign scan_mode_o     = scan_reg;
    assign closed_ch_o     = ch_reg;
    assign relay_close_o   = relay_reg;
    assign measure_req_o   = meas_reg;
    assign store_we_o      = we_reg;
    assign store_addr_o    = addr_reg;
    assign out_trig_o      = trig_reg;
    assign ref_junction_o  = refj_reg;
    assign sample_count_o  = samp_reg;
    assign trigger_count_o = tcnt_reg;
endmodule : sss_sequencer
`default_nettype wire

// File: include/sss_cfg.svh
// Constants for the step/scan sequencer
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_CLK_HZ        40000000
`define SSS_MS_CYCLES     (`SSS_CLK_HZ / 1000)
`define SSS_MAX_RDG       11'h0400
`define SSS_CNT_W         11
`define SSS_CH_W          4
`define SSS_MS_W          32
`define SSS_REF_CH        4'h1
`endif

// File: include/sss_pkg.sv
// Types for the step/scan sequencer
package sss_pkg;
    typedef enum logic [2:0] {
        SSS_IDLE,
        SSS_WAIT_TIMER,
        SSS_DELAY,
        SSS_CLOSE,
        SSS_MEASURE,
        SSS_NEXT
    } sss_state_t;
endpackage : sss_pkg

// File: test/sss_assertions.sv
// Port-level assertions for the step/scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_assertions (
    input wire logic                  ref_clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  step_start_i,
    input wire logic                  scan_start_i,
    input wire logic                  halt_i,
    input wire logic                  external_mode_i,
    input wire logic                  busy_o,
    input wire logic                  scan_mode_o,
    input wire logic [`SSS_CH_W-1:0]  closed_ch_o,
    input wire logic                  relay_close_o,
    input wire logic                  measure_req_o,
    input wire logic                  store_we_o,
    input wire logic                  out_trig_o,
    input wire logic                  ref_junction_o,
    input wire logic [`SSS_CNT_W-1:0] sample_count_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_go;
        (step_start_i || scan_start_i) && !busy_o && !halt_i;
    endsequence
    sequence s_halted;
        !busy_o && !out_trig_o && !store_we_o && !relay_close_o;
    endsequence
    a_halt_idle: assert property (halt_i |=> s_halted)
        else $error("halt left the sequencer active");
    a_start_busy: assert property (s_go |=> busy_o)
        else $error("start in idle did not begin an operation");
    a_relay_busy: assert property (relay_close_o |-> busy_o)
        else $error("relay closed outside an operation");
    a_ref_junction: assert property (ref_junction_o |-> busy_o && closed_ch_o == `SSS_REF_CH)
        else $error("reference junction flagged outside an operation");
    a_meas_relay: assert property (measure_req_o |-> relay_close_o && !external_mode_i)
        else $error("measurement requested without an internal closure");
    a_store_busy: assert property (store_we_o |-> busy_o || $past(busy_o))
        else $error("reading stored outside an operation");
    a_trig_pulse: assert property (out_trig_o |=> !out_trig_o)
        else $error("output trigger longer than one cycle");
    a_step_samples: assert property (busy_o && $past(busy_o) && !scan_mode_o
        |-> sample_count_o == 11'h001)
        else $error("step sample count is not one");
endmodule : sss_assertions
bind sss_sequencer sss_assertions i_chk (.ref_clk_i, .rst_n_i, .step_start_i, .scan_start_i,
    .halt_i, .external_mode_i, .busy_o, .scan_mode_o, .closed_ch_o, .relay_close_o,
    .measure_req_o, .store_we_o, .out_trig_o, .ref_junction_o, .sample_count_o);
`default_nettype wire

// File: test/sss_meter_model.sv
// Far-side model: scanner relays with measurement, or an outside switching unit
`timescale 1ns/1ps
`default_nettype none
module sss_meter_model (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       measure_req_i,
    input wire logic       busy_i,
    input wire logic       ext_i,
    input wire logic [3:0] lat_i,
    output logic           reading_done_o,
    output logic           outside_trigger_source_o
);
    logic [3:0] wait_q;
    logic       pend;
    logic [2:0] tick;
    always @(posedge clk_i) begin
        reading_done_o <= 1'b0;
        outside_trigger_source_o <= 1'b0;
        if (!rst_n_i) begin
            pend <= 1'b0;
            tick <= 3'h0;
        end else begin
            if (measure_req_i && !ext_i) begin
                pend <= 1'b1;
                wait_q <= lat_i;
            end else if (pend && wait_q == 4'h0) begin
                reading_done_o <= 1'b1;
                pend <= 1'b0;
            end else if (pend) begin
                wait_q <= wait_q - 4'h1;
            end
            // Outside unit closes a channel every eighth cycle and signals it
            tick <= (busy_i && ext_i) ? tick + 3'h1 : 3'h0;
            if (busy_i && ext_i && tick == 3'h7) outside_trigger_source_o <= 1'b1;
        end
    end
endmodule : sss_meter_model
`default_nettype wire

// File: test/tb_step_scan_sequencer.sv
// Self-checking bench for the step/scan sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module tb_step_scan_sequencer;
    logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, step_go = 1'b0, scan_go = 1'b0;
    logic        halt = 1'b0, ext = 1'b0, rd_done, outside_trigger_source;
    logic        busy, scan_m, relay, meas, we, trig, refj;
    logic [3:0]  ch, f_ch = 4'h1, l_ch = 4'h1, lat = 4'h0;
    logic [10:0] cnt = 11'h001, addr, smp, tcnt;
    logic        tmr_en = 1'b0;
    logic [31:0] tmr_ms = 32'h0000_0000;
    int          error_cnt = 0, checked = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    sss_sequencer i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .step_start_i(step_go),
        .scan_start_i(scan_go), .halt_i(halt), .external_mode_i(ext), .first_ch_i(f_ch),
        .last_ch_i(l_ch), .reading_count_setting_i(cnt), .timer_en_i(tmr_en),
        .timer_ms_i(tmr_ms), .delay_ms_i(32'h0000_0000),
        .outside_trigger_source_i(outside_trigger_source), .reading_done_i(rd_done), .busy_o(busy),
        .scan_mode_o(scan_m), .closed_ch_o(ch), .relay_close_o(relay), .measure_req_o(meas),
        .store_we_o(we), .store_addr_o(addr), .out_trig_o(trig), .ref_junction_o(refj),
        .sample_count_o(smp), .trigger_count_o(tcnt));
    sss_meter_model i_far (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .measure_req_i(meas),
        .busy_i(busy), .ext_i(ext), .lat_i(lat), .reading_done_o(rd_done),
        .outside_trigger_source_o(outside_trigger_source));
    task automatic final_report;
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk
    // Config is disturbed right after the start edge; the op must keep its own copy
    task automatic run_op(input logic sc, input logic [3:0] f, l, input logic [10:0] n);
        int len, et, nt, ns, nm, idle, lim;
        len = l - f + 1;
        et = sc ? (n + len - 1) / len : n;
        nt = 0; ns = 0; nm = 0; idle = 0; lim = 0;
        @(posedge ref_clk_i);
        f_ch <= f; l_ch <= l; cnt <= n;
        @(posedge ref_clk_i);
        step_go <= !sc; scan_go <= sc;
        @(posedge ref_clk_i);
        step_go <= 1'b0; scan_go <= 1'b0; cnt <= 11'h003; l_ch <= f;
        while (idle < 6 && lim < 20000) begin
            @(posedge ref_clk_i);
            #1;
            if (meas) begin
                chk("closed channel", ch, f + nm % len);
                chk("reference flag", refj, ch == 4'h1);
                nm++;
            end
            if (we) begin
                chk("store address", addr, ns);
                ns++;
            end
            if (trig) nt++;
            idle = busy ? 0 : idle + 1;
            lim++;
        end
        chk("operation end", lim < 20000, 1);
        chk("triggers", nt, et);
        chk("stores", ns, n);
        chk("closures", nm, ext ? 0 : (sc ? et * len : n));
        chk("sample count", smp, sc ? len : 1);
        chk("trigger count", tcnt, et);
    endtask : run_op
    // Timed scan: first pass at once, second pass held by the interval timer
    task automatic timer_op;
        int cyc, t1, gap, nt;
        cyc = 0; t1 = 0; gap = 0; nt = 0;
        @(posedge ref_clk_i);
        f_ch <= 4'h1; l_ch <= 4'h2; cnt <= 11'h004; tmr_en <= 1'b1; tmr_ms <= 32'h0000_0001;
        @(posedge ref_clk_i);
        scan_go <= 1'b1;
        @(posedge ref_clk_i);
        scan_go <= 1'b0;
        while ((busy || cyc < 3) && cyc < 45000) begin
            @(posedge ref_clk_i);
            #1;
            cyc++;
            if (trig) begin
                nt++;
                if (nt == 1) t1 = cyc;
                else gap = cyc - t1;
            end
        end
        tmr_en <= 1'b0;
        chk("timed triggers", nt, 2);
        chk("first pass at once", t1 < 30, 1);
        chk("later pass waits", gap > 30 && gap < 40100, 1);
        repeat (4) @(posedge ref_clk_i);
    endtask : timer_op
    task automatic halt_mid;
        @(posedge ref_clk_i);
        f_ch <= 4'h1; l_ch <= 4'ha; cnt <= 11'h014; step_go <= 1'b1;
        @(posedge ref_clk_i);
        step_go <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        halt <= 1'b1;
        @(posedge ref_clk_i);
        halt <= 1'b0;
        #1;
        chk("busy after halt", busy, 0);
        chk("relay after halt", relay, 0);
        // A reading already in flight must drain before the next op
        repeat (12) @(posedge ref_clk_i);
    endtask : halt_mid
    initial begin
        repeat (75000) @(posedge ref_clk_i);
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        run_op(1'b0, 4'h1, 4'h4, 11'h004);
        run_op(1'b1, 4'h1, 4'h4, 11'h004);
        lat <= 4'h9;
        run_op(1'b0, 4'h2, 4'h4, 11'h007);
        run_op(1'b1, 4'h2, 4'h4, 11'h007);
        lat <= 4'h0;
        run_op(1'b0, 4'h1, 4'h4, 11'h002);
        run_op(1'b1, 4'h1, 4'h4, 11'h002);
        run_op(1'b1, 4'h1, 4'ha, 11'h400);
        timer_op;
        halt_mid;
        ext <= 1'b1;
        run_op(1'b0, 4'h1, 4'h3, 11'h003);
        run_op(1'b1, 4'h1, 4'h3, 11'h005);
        final_report;
    end
endmodule : tb_step_scan_sequencer
`default_nettype wire
